// ==== logic/dbsz_regs.vh ====
// register map, field positions and cycle-kind and source encodings for the bus sizing block
// What this block does
// (RQ1) byte write with high enable only copies upper data lane onto lower lane
// (RQ2) word write seeing narrow request at last state two gets second write cycle
// (RQ3) second cycle of a split word write keeps low byte enable inactive
// (RQ4) split word read reruns with low enable off, lower lane fills upper byte
// (RQ5) byte access with only low enable active ignores the narrow request
// (RQ6) only read and write cycles split; acknowledge and halt cycles never do
// (RQ7) refresh cycles drive both byte enables inactive and ignore narrow request
// (RQ8) second cycle of a split access keeps the same address on the bus
// (RQ9) no address pipelining on cycles that may be narrowed
// (RQ10) narrow device sits on lower lane, uses low enable as a0, requests in state two
// (RQ11) internal chip-select logic may drive the narrow request instead of the pin
// (RQ12) gate bit clear forces address line twenty low
// (RQ13) forcing applies to core addresses only, not dma or refresh
// (RQ14) gate configuration register resets to 0x0e, bit one is the gate
// (RQ15) word access without narrow request completes in one sixteen-bit cycle
`ifndef DBSZ_REGS_VH
`define DBSZ_REGS_VH
`define DBSZ_ADDR_W 16
`define DBSZ_OFF_GATE_CFG 16'hf092
`define DBSZ_OFF_STATUS 16'hf094
`define DBSZ_GATE_CFG_RST 8'h0e
`define DBSZ_GATE_BIT 1
`define DBSZ_A20_BIT 20
`define DBSZ_CYC_READ 2'h0
`define DBSZ_CYC_WRITE 2'h1
`define DBSZ_CYC_INTA 2'h2
`define DBSZ_CYC_HALT 2'h3
`define DBSZ_SRC_CORE 2'h0
`define DBSZ_SRC_DMA 2'h1
`define DBSZ_SRC_REFRESH 2'h2
`endif

// ==== logic/dbsz_gate_cfg.v ====
// avalon-mm slave holding the gate configuration and status registers
`timescale 1ns/1ps
`include "dbsz_regs.vh"
module dbsz_gate_cfg (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [15:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [7:0] status_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output wire gate_o
);
    reg [7:0] gate_cfg_ff;
    reg ack_ff;
    wire req;
    wire hit_cfg;
    wire hit_sts;
    assign req = avs_read_i | avs_write_i;
    assign hit_cfg = (avs_address_i == `DBSZ_OFF_GATE_CFG);
    assign hit_sts = (avs_address_i == `DBSZ_OFF_STATUS);
    // one wait cycle, then answer
    assign avs_waitrequest_o = req & ~ack_ff;
    assign gate_o = gate_cfg_ff[`DBSZ_GATE_BIT];
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_cfg_ff <= `DBSZ_GATE_CFG_RST; // RQ14
            ack_ff <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            ack_ff <= req & ~ack_ff;
            // write lands at the edge where waitrequest is low
            if (avs_write_i & ack_ff & hit_cfg & avs_byteenable_i[0]) begin
                gate_cfg_ff <= avs_writedata_i[7:0];
            end
            if (avs_read_i & ~ack_ff) begin
                if (hit_cfg) begin
                    avs_readdata_o <= {24'h00_0000, gate_cfg_ff};
                end else if (hit_sts) begin
                    avs_readdata_o <= {24'h00_0000, status_i};
                end else begin
                    avs_readdata_o <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // dbsz_gate_cfg

// ==== logic/dbsz_bus_sizer.v ====
// bus interface: dynamic 8/16-bit sizing and address line 20 gating
`timescale 1ns/1ps
`include "dbsz_regs.vh"
module dbsz_bus_sizer #(
    parameter ADDR_W = 26
) (
    input wire sys_clk_i,
    input wire nrst_i,
    // register bus
    input wire [15:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // internal requester side
    input wire req_valid_i,
    input wire [1:0] req_kind_i,
    input wire [1:0] req_src_i,
    input wire [ADDR_W-1:0] req_addr_i,
    input wire req_high_be_i,
    input wire req_low_be_i,
    input wire [15:0] req_wdata_i,
    input wire cs_narrow_req_i,
    output wire req_ready_o,
    output reg rsp_valid_o,
    output reg [15:0] rsp_rdata_o,
    // external bus
    output reg [ADDR_W-1:0] bus_addr_o,
    output reg high_byte_enable_n_o,
    output reg low_byte_enable_n_o,
    output reg bus_write_o,
    output reg bus_cycle_o,
    output reg [15:0] bus_data_o,
    output reg bus_data_oe_o,
    input wire [15:0] bus_data_i,
    input wire ready_n_i,
    input wire narrow_bus_request_n_i
);
    localparam ST_IDLE = 2'h0;
    localparam ST_T1 = 2'h1;
    localparam ST_T2 = 2'h2;
    reg [1:0] rst_sync_ff;
    wire rst_n;
    reg [1:0] rdy_sync_ff;
    reg [1:0] nbr_sync_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg second_ff;
    reg [1:0] kind_ff;
    reg is_refresh_ff;
    reg [7:0] low_byte_ff;
    reg split_cnt_ff;
    reg [6:0] split_total_ff;
    wire gate;
    wire ready_seen;
    wire narrow_seen;
    wire splittable;
    wire do_split;
    wire [ADDR_W-1:0] gated_addr;
    wire [7:0] status;

    // reset release through two flops
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // pin inputs synchronised
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_sync_ff <= 2'b11;
            nbr_sync_ff <= 2'b11;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[0], ready_n_i};
            nbr_sync_ff <= {nbr_sync_ff[0], narrow_bus_request_n_i};
        end
    end

    dbsz_gate_cfg u_cfg (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .status_i(status),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .gate_o(gate)
    );

    function [ADDR_W-1:0] gate_addr;
        input [ADDR_W-1:0] a;
        input [1:0] src;
        input g;
        begin
            gate_addr = a;
            if ((src == `DBSZ_SRC_CORE) && !g) begin // RQ13
                gate_addr[`DBSZ_A20_BIT] = 1'b0; // RQ12
            end
        end
    endfunction

    assign gated_addr = gate_addr(req_addr_i, req_src_i, gate);
    assign ready_seen = (state_ff == ST_T2) & ~rdy_sync_ff[1];
    // external pin or internal chip select may ask for a narrow cycle
    assign narrow_seen = ~nbr_sync_ff[1] | cs_narrow_req_i; // RQ11
    // split only word reads/writes, never refresh, inta or halt
    assign splittable = ~second_ff & ~is_refresh_ff & ~high_byte_enable_n_o // RQ6 RQ7
        & ~low_byte_enable_n_o & ((kind_ff == `DBSZ_CYC_READ) // RQ5
        | (kind_ff == `DBSZ_CYC_WRITE));
    assign do_split = ready_seen & narrow_seen & splittable; // RQ2 RQ4 RQ15
    // non-pipelined: a new request is taken only from idle
    assign req_ready_o = (state_ff == ST_IDLE); // RQ9
    assign status = {split_total_ff, gate};

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid_i) begin
                    nxt_state = ST_T1;
                end
            end
            ST_T1: begin
                // stale ready of the previous cycle must leave the synchroniser first
                if (rdy_sync_ff[1]) begin
                    nxt_state = ST_T2;
                end
            end
            ST_T2: begin
                if (do_split) begin
                    nxt_state = ST_T1;
                end else if (ready_seen) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            second_ff <= 1'b0;
            kind_ff <= `DBSZ_CYC_READ;
            is_refresh_ff <= 1'b0;
            low_byte_ff <= 8'h00;
            split_cnt_ff <= 1'b0;
            split_total_ff <= 7'h00;
            bus_addr_o <= {ADDR_W{1'b0}};
            high_byte_enable_n_o <= 1'b1;
            low_byte_enable_n_o <= 1'b1;
            bus_write_o <= 1'b0;
            bus_cycle_o <= 1'b0;
            bus_data_o <= 16'h0000;
            bus_data_oe_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            rsp_valid_o <= 1'b0;
            split_cnt_ff <= 1'b0;
            if ((state_ff == ST_IDLE) && req_valid_i) begin
                kind_ff <= req_kind_i;
                second_ff <= 1'b0;
                is_refresh_ff <= (req_src_i == `DBSZ_SRC_REFRESH);
                bus_addr_o <= gated_addr;
                bus_cycle_o <= 1'b1;
                bus_write_o <= (req_kind_i == `DBSZ_CYC_WRITE);
                if (req_src_i == `DBSZ_SRC_REFRESH) begin
                    high_byte_enable_n_o <= 1'b1; // RQ7
                    low_byte_enable_n_o <= 1'b1; // RQ7
                end else if ((req_kind_i == `DBSZ_CYC_INTA)
                        || (req_kind_i == `DBSZ_CYC_HALT)) begin
                    high_byte_enable_n_o <= 1'b1; // RQ6
                    low_byte_enable_n_o <= 1'b0; // RQ6
                end else begin
                    high_byte_enable_n_o <= ~req_high_be_i;
                    low_byte_enable_n_o <= ~req_low_be_i;
                end
                if (req_kind_i == `DBSZ_CYC_WRITE) begin
                    bus_data_oe_o <= 1'b1;
                    if (req_high_be_i && !req_low_be_i) begin
                        bus_data_o <= {req_wdata_i[15:8], req_wdata_i[15:8]}; // RQ1
                    end else begin
                        bus_data_o <= req_wdata_i;
                    end
                end else begin
                    bus_data_oe_o <= 1'b0;
                end
            end else if (do_split) begin
                // rerun with same address, upper byte only
                second_ff <= 1'b1;
                split_cnt_ff <= 1'b1;
                low_byte_ff <= bus_data_i[7:0];
                low_byte_enable_n_o <= 1'b1; // RQ3 RQ4
                bus_addr_o <= bus_addr_o; // RQ8
                bus_data_o <= {bus_data_o[15:8], bus_data_o[15:8]}; // RQ2
            end else if (ready_seen) begin
                bus_cycle_o <= 1'b0;
                bus_data_oe_o <= 1'b0;
                high_byte_enable_n_o <= 1'b1;
                low_byte_enable_n_o <= 1'b1;
                rsp_valid_o <= 1'b1;
                if (second_ff) begin
                    rsp_rdata_o <= {bus_data_i[7:0], low_byte_ff}; // RQ4
                end else if (high_byte_enable_n_o == 1'b0 && low_byte_enable_n_o) begin
                    rsp_rdata_o <= {bus_data_i[15:8], bus_data_i[7:0]};
                end else begin
                    rsp_rdata_o <= bus_data_i; // RQ15
                end
            end
            if (split_cnt_ff) begin
                split_total_ff <= split_total_ff + 7'h01;
            end
        end
    end
endmodule // dbsz_bus_sizer

// ==== dv/dbsz_monitor.sv ====
// checker for the bus sizing block ports
`timescale 1ns/1ps
`include "dbsz_regs.vh"
module dbsz_monitor #(
    parameter ADDR_W = 26
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire req_valid_i,
    input wire [1:0] req_kind_i,
    input wire [1:0] req_src_i,
    input wire req_ready_o,
    input wire rsp_valid_o,
    input wire [ADDR_W-1:0] bus_addr_o,
    input wire high_byte_enable_n_o,
    input wire low_byte_enable_n_o,
    input wire bus_write_o,
    input wire bus_cycle_o,
    input wire [15:0] bus_data_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    wire acc = req_valid_i && req_ready_o;
    reg prev_cyc_ff = 1'b0;
    always @(posedge sys_clk_i) prev_cyc_ff <= bus_cycle_o;
    wire in_cyc = bus_cycle_o && prev_cyc_ff;
    AST_WLANE: assert property (bus_cycle_o && bus_write_o && low_byte_enable_n_o
        && !high_byte_enable_n_o |-> bus_data_o[7:0] == bus_data_o[15:8])
        else $error("lower lane lacks upper byte");
    AST_ADDR_HOLD: assert property (in_cyc |-> $stable(bus_addr_o))
        else $error("address moved inside a cycle");
    AST_NO_PIPE: assert property (req_ready_o |-> !bus_cycle_o)
        else $error("request taken while a cycle runs");
    AST_LE_STAY: assert property (in_cyc |-> !$fell(low_byte_enable_n_o))
        else $error("low enable came back inside a cycle");
    AST_SPLIT_HI: assert property (in_cyc && $rose(low_byte_enable_n_o)
        |-> !high_byte_enable_n_o) else $error("second cycle without high enable");
    AST_REFRESH_BE: assert property (acc && req_src_i == `DBSZ_SRC_REFRESH
        |=> (high_byte_enable_n_o && low_byte_enable_n_o) [*6]) else $error("refresh enable");
    AST_INTA_BYTE: assert property (acc && req_kind_i[1] && req_src_i != `DBSZ_SRC_REFRESH
        |-> ##[1:2] (bus_cycle_o && high_byte_enable_n_o && !low_byte_enable_n_o))
        else $error("special cycle not byte wide");
    AST_RSP_BOUND: assert property (acc |-> ##[2:60] rsp_valid_o)
        else $error("no response to request");
    CV_WRITE: cover property (acc && req_kind_i == `DBSZ_CYC_WRITE);
    CV_SPLIT: cover property (in_cyc && $rose(low_byte_enable_n_o));
    CV_REFRESH: cover property (acc && req_src_i == `DBSZ_SRC_REFRESH);
endmodule // dbsz_monitor
bind dbsz_bus_sizer dbsz_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ==== dv/dbsz_ext_mem.sv ====
// external memory model answering with ready and optional narrow request
`timescale 1ns/1ps
module dbsz_ext_mem #(
    parameter ADDR_W = 26,
    parameter [15:0] MEM = 16'hc3a5
) (
    input wire clk_i,
    input wire bus_cycle_i,
    input wire bus_write_i,
    input wire low_byte_enable_n_i,
    input wire [15:0] bus_data_i,
    input wire [ADDR_W-1:0] bus_addr_i,
    input wire narrow_i,
    input wire [3:0] wait_i,
    output logic ready_n_o,
    output logic narrow_n_o,
    output logic [15:0] data_o,
    output logic [15:0] wlog_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [7:0] cnt_o
);
    logic [15:0] pat = 16'h0;
    wire [7:0] lob = low_byte_enable_n_i ? MEM[15:8] : MEM[7:0];
    // undriven lanes change every cycle
    assign data_o = ready_n_o ? pat : (narrow_i ? {pat[7:0], lob} : MEM);
    always @(posedge clk_i) pat <= pat + 16'h1357;
    initial begin
        ready_n_o = 1'b1;
        narrow_n_o = 1'b1;
        wlog_o = 16'h0;
        addr_o = '0;
        cnt_o = 8'h0;
        forever begin
            @(posedge clk_i);
            if (bus_cycle_i === 1'b1) begin
                repeat (wait_i) @(posedge clk_i);
                ready_n_o <= 1'b0;
                narrow_n_o <= !narrow_i;
                if (bus_write_i) wlog_o <= {wlog_o[7:0], bus_data_i[7:0]};
                addr_o <= bus_addr_i;
                cnt_o <= cnt_o + 8'h1;
                repeat (3) @(posedge clk_i);
                ready_n_o <= 1'b1;
                narrow_n_o <= 1'b1;
                repeat (2) @(posedge clk_i);
            end
        end
    end
endmodule // dbsz_ext_mem

// ==== dv/tb.sv ====
// self-checking bench for the bus sizing block
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [3:0] k, s, h, l, p, c, n, m; logic [15:0] e;} dbsz_row_t;
    localparam logic [25:0] ADR = 26'h0112345;
    // kind src hbe lbe pin cs cycles check expect
    localparam dbsz_row_t ROWS [10] = '{48'h0011_0011_c3a5,
        48'h0011_1021_c3a5,
        48'h1011_1022_3412,
        48'h1011_0012_1234,
        48'h1010_1012_3412,
        48'h0001_1010_0000,
        48'h2001_1010_0000,
        48'h3001_1010_0000,
        48'h0211_1010_0000,
        48'h0011_0121_a5a5};
    logic sys_clk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, req_valid_i = 0;
    logic req_high_be_i = 0, req_low_be_i = 0, cs_narrow_req_i = 0, npin = 0;
    logic [1:0] req_kind_i = '0, req_src_i = '0;
    logic [3:0] wst = '0;
    logic [15:0] avs_address_i = '0;
    logic [25:0] req_addr_i = ADR;
    logic [31:0] avs_writedata_i = '0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, req_ready_o, rsp_valid_o, high_byte_enable_n_o, low_byte_enable_n_o;
    wire bus_write_o, bus_cycle_o, ready_n_i, narrow_bus_request_n_i;
    wire [15:0] rsp_rdata_o, bus_data_o, bus_data_i, wlog;
    wire [25:0] bus_addr_o, paddr;
    wire [7:0] pcnt;
    int n_mismatch = 0, checks_done = 0;
    dbsz_bus_sizer uut (.*, .avs_byteenable_i(4'hf), .req_wdata_i(16'h1234), .bus_data_oe_o());
    dbsz_ext_mem u_mem (.clk_i(sys_clk_i), .bus_cycle_i(bus_cycle_o), .bus_write_i(bus_write_o),
        .low_byte_enable_n_i(low_byte_enable_n_o), .bus_data_i(bus_data_o),
        .bus_addr_i(bus_addr_o), .narrow_i(npin), .wait_i(wst), .ready_n_o(ready_n_i),
        .narrow_n_o(narrow_bus_request_n_i), .data_o(bus_data_i), .wlog_o(wlog),
        .addr_o(paddr), .cnt_o(pcnt));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    initial begin
        #300000;
        n_mismatch++;
        complete_run;
    end
    task automatic complete_run;
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic av(input logic w, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] q);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic op(input dbsz_row_t r, output logic [15:0] q, output logic [7:0] n);
        logic [7:0] c0;
        c0 = pcnt;
        req_kind_i <= r.k[1:0];
        req_src_i <= r.s[1:0];
        req_high_be_i <= r.h[0];
        req_low_be_i <= r.l[0];
        npin <= r.p[0];
        cs_narrow_req_i <= r.c[0];
        req_valid_i <= 1'b1;
        do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do @(posedge sys_clk_i); while (rsp_valid_o !== 1'b1);
        q = rsp_rdata_o;
        n = pcnt - c0;
        @(posedge sys_clk_i);
    endtask
    initial begin
        logic [31:0] q;
        logic [15:0] d;
        logic [7:0] n;
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        cmp("idle pins", {high_byte_enable_n_o, low_byte_enable_n_o, bus_cycle_o}, 32'h6);
        av(1'b0, 16'hf092, 32'h0, q);
        cmp("gate cfg reset", q, 32'h0e);
        av(1'b0, 16'hf0a0, 32'h0, q);
        cmp("unmapped read", q, 32'h0);
        foreach (ROWS[i]) begin
            op(ROWS[i], d, n);
            cmp("cycle count", n, ROWS[i].n);
            if (ROWS[i].m == 4'h1) cmp("read data", d, ROWS[i].e);
            if (ROWS[i].m == 4'h2) cmp("lower lane writes", wlog, ROWS[i].e);
        end
        av(1'b0, 16'hf094, 32'h0, q);
        cmp("status", q, 32'h07);
        wst <= 4'h4;
        op(ROWS[0], d, n);
        cmp("core addr open", paddr, ADR);
        av(1'b1, 16'hf092, 32'h0c, q);
        av(1'b0, 16'hf092, 32'h0, q);
        cmp("gate cfg rw", q, 32'h0c);
        op(ROWS[0], d, n);
        cmp("core addr gated", paddr, ADR & ~26'h100000);
        op(48'h0111_0011_c3a5, d, n);
        cmp("dma addr", paddr, ADR);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        av(1'b0, 16'hf092, 32'h0, q);
        cmp("gate cfg rereset", q, 32'h0e);
        complete_run;
    end
endmodule // tb
